// *** rtl/diag_flags_pkg.sv ***
// Constants for the sticky diagnostic error flag register
package diag_flags_pkg;
  localparam int          DATA_W        = 16;
  localparam int          FRAME_BITS    = 16;
  localparam int          CNT_W         = 4;
  localparam int          BIT_OVERRUN   = 1;
  localparam int          BIT_FLASH     = 2;
  localparam int          BIT_FRAMING   = 3;
  localparam logic [15:0] FLAGS_RESET   = 16'h0000;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;
endpackage

// *** rtl/sclk_frame_check.sv ***
// Counts serial clock edges of a transaction and flags bad framing
`timescale 1ns/1ns
module sclk_frame_check (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sclkEdge,
  input  wire logic frameEnd,
  output logic      framingErr
);
  logic [diag_flags_pkg::CNT_W-1:0] count_r;
  logic [diag_flags_pkg::CNT_W-1:0] count_nxt;
  logic                             err_nxt;

  // Counter wraps at the frame size, so a zero count means a whole multiple
  assign count_nxt = frameEnd ? diag_flags_pkg::CNT_ZERO
                   : sclkEdge ? count_r + diag_flags_pkg::CNT_ONE : count_r;
  assign err_nxt   = frameEnd && (count_r != diag_flags_pkg::CNT_ZERO);

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r    <= diag_flags_pkg::CNT_ZERO;
      framingErr <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      framingErr <= err_nxt;
    end
  end

  a_err_after_end: assert property (@(posedge clk) disable iff (rst)
    framingErr
    |-> $past(frameEnd))
    else $error("framing error without frame end");

  a_count_restart: assert property (@(posedge clk) disable iff (rst)
    frameEnd
    |=> count_r == diag_flags_pkg::CNT_ZERO)
    else $error("frame counter not restarted");
endmodule

// *** rtl/sticky_diag_error_flags.sv ***
// Sticky diagnostic error flag register, clear on read
`timescale 1ns/1ns
module sticky_diag_error_flags (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclkEdge,
  input  wire logic        frameEnd,
  input  wire logic        flashUpdateDone,
  input  wire logic        flashUpdateOk,
  input  wire logic        overrun,
  input  wire logic        flagsRead,
  output logic [15:0]      readData,
  output logic [15:0]      diagnosticErrorFlags
);
  logic        framingErr;
  logic [15:0] flags_r;
  logic [15:0] flags_nxt;
  logic [15:0] events;
  logic        flashFail;
  logic [15:0] usedMask;
  logic [15:0] readData_nxt;
  logic        overrunFlag;
  logic        flashFlag;
  logic        framingFlag;

  sclk_frame_check u_frame (
    .clk        (clk),
    .rst        (rst),
    .sclkEdge   (sclkEdge),
    .frameEnd   (frameEnd),
    .framingErr (framingErr)
  );

  // Flash failure is decoded only while flashUpdateDone is high and flashUpdateOk is low
  assign flashFail = flashUpdateDone && !flashUpdateOk;

  // Named views of the three live flags keep the checks readable
  assign overrunFlag = flags_r[diag_flags_pkg::BIT_OVERRUN];
  assign flashFlag   = flags_r[diag_flags_pkg::BIT_FLASH];
  assign framingFlag = flags_r[diag_flags_pkg::BIT_FRAMING];

  // One slice per flag bit; spare bits have no cause and never latch
  generate
    for (genvar i = 0; i < diag_flags_pkg::DATA_W; i = i + 1) begin : g_bit
      if (i == diag_flags_pkg::BIT_FRAMING) begin : g_framing
        assign events[i]   = framingErr;
        assign usedMask[i] = 1'b1;
      end else if (i == diag_flags_pkg::BIT_FLASH) begin : g_flash
        assign events[i]   = flashFail;
        assign usedMask[i] = 1'b1;
      end else if (i == diag_flags_pkg::BIT_OVERRUN) begin : g_overrun
        assign events[i]   = overrun;
        assign usedMask[i] = 1'b1;
      end else begin : g_spare
        assign events[i]   = 1'b0;
        assign usedMask[i] = 1'b0;
      end

      // Set beats clear, so a live cause re-arms right after the read
      assign flags_nxt[i] = (flags_r[i] && !flagsRead)
                          || events[i];

      a_bit_hold: assert property (@(posedge clk) disable iff (rst)
        flags_r[i] && !flagsRead
        |=> flags_r[i])
        else $error("flag bit dropped without read");

      a_bit_clear: assert property (@(posedge clk) disable iff (rst)
        flagsRead && !events[i]
        |=> !flags_r[i])
        else $error("flag bit not cleared by read");

      a_bit_rearm: assert property (@(posedge clk) disable iff (rst)
        events[i]
        |=> flags_r[i])
        else $error("live cause did not set its flag");

      a_bit_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(flags_r[i])
        |-> $past(events[i]))
        else $error("flag bit set without cause");

      a_bit_capture: assert property (@(posedge clk) disable iff (rst)
        flagsRead
        |=> readData[i] == $past(flags_r[i]))
        else $error("read data bit wrong");
    end
  endgenerate

  assign readData_nxt = flagsRead ? flags_r : readData;

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r  <= diag_flags_pkg::FLAGS_RESET;
      readData <= diag_flags_pkg::FLAGS_RESET;
    end else begin
      flags_r  <= flags_nxt;
      readData <= readData_nxt;
    end
  end

  // The flags are a register already, so the port needs no extra stage
  assign diagnosticErrorFlags = flags_r;

  // Whole-register behaviour around reads and reset
  a_read_clears: assert property (@(posedge clk) disable iff (rst)
    flagsRead && !overrun && !flashFail && !framingErr
    |=> flags_r == diag_flags_pkg::FLAGS_RESET)
    else $error("flags not cleared by read");

  a_read_returns: assert property (@(posedge clk) disable iff (rst)
    flagsRead
    |=> readData == $past(flags_r))
    else $error("read data wrong");

  a_read_steady: assert property (@(posedge clk) disable iff (rst)
    !flagsRead
    |=> $stable(readData))
    else $error("read data moved without a read");

  a_double_read: assert property (@(posedge clk) disable iff (rst)
    flagsRead ##1 flagsRead
    |=> readData == $past(events, 2))
    else $error("second read lost an event");

  a_spare_zero: assert property (@(posedge clk) disable iff (rst)
    ((flags_r | readData) & ~usedMask)
    == diag_flags_pkg::FLAGS_RESET)
    else $error("spare flag bit set");

  a_reset_clears: assert property (@(posedge clk)
    rst
    |=> flags_r == diag_flags_pkg::FLAGS_RESET
        && readData == diag_flags_pkg::FLAGS_RESET)
    else $error("reset left flags set");

  a_sticky_hold: assert property (@(posedge clk) disable iff (rst)
    !flagsRead
    |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag dropped without read");

  // Per-flag set, hold and clear
  a_overrun_sets: assert property (@(posedge clk) disable iff (rst)
    overrun
    |=> overrunFlag)
    else $error("overrun not flagged");

  a_flash_sets: assert property (@(posedge clk) disable iff (rst)
    flashUpdateDone && !flashUpdateOk
    |=> flashFlag)
    else $error("flash failure not flagged");

  a_framing_sets: assert property (@(posedge clk) disable iff (rst)
    framingErr
    |=> framingFlag)
    else $error("framing error not flagged");

  a_overrun_hold: assert property (@(posedge clk) disable iff (rst)
    overrunFlag && !flagsRead
    |=> overrunFlag)
    else $error("overrun flag dropped");

  a_flash_hold: assert property (@(posedge clk) disable iff (rst)
    flashFlag && !flagsRead
    |=> flashFlag)
    else $error("flash flag dropped");

  a_framing_hold: assert property (@(posedge clk) disable iff (rst)
    framingFlag && !flagsRead
    |=> framingFlag)
    else $error("framing flag dropped");

  a_overrun_clear: assert property (@(posedge clk) disable iff (rst)
    flagsRead && !overrun
    |=> !overrunFlag)
    else $error("overrun flag survived read");

  a_flash_clear: assert property (@(posedge clk) disable iff (rst)
    flagsRead && !flashFail
    |=> !flashFlag)
    else $error("flash flag survived read");

  a_framing_clear: assert property (@(posedge clk) disable iff (rst)
    flagsRead && !framingErr
    |=> !framingFlag)
    else $error("framing flag survived read");

  // A cause that persists or coincides with the read is not lost
  a_rearm_cause: assert property (@(posedge clk) disable iff (rst)
    flagsRead ##1 overrun
    |=> overrunFlag)
    else $error("persisting cause not re-flagged");

  a_rearm_flash: assert property (@(posedge clk) disable iff (rst)
    flagsRead ##1 flashFail
    |=> flashFlag)
    else $error("persisting flash failure not re-flagged");

  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    flagsRead && framingErr
    |=> framingFlag)
    else $error("event lost on clearing read");

  a_set_wins_ovr: assert property (@(posedge clk) disable iff (rst)
    flagsRead && overrun
    |=> overrunFlag)
    else $error("overrun lost on clearing read");

  a_set_wins_flash: assert property (@(posedge clk) disable iff (rst)
    flagsRead && flashFail
    |=> flashFlag)
    else $error("flash failure lost on clearing read");

  a_no_spurious: assert property (@(posedge clk) disable iff (rst)
    $rose(overrunFlag)
    |-> $past(overrun))
    else $error("overrun flag without cause");

  a_flash_no_spur: assert property (@(posedge clk) disable iff (rst)
    $rose(flashFlag)
    |-> $past(flashFail))
    else $error("flash flag without cause");

  a_framing_no_spur: assert property (@(posedge clk) disable iff (rst)
    $rose(framingFlag)
    |-> $past(framingErr))
    else $error("framing flag without cause");

  a_frame_latency: assert property (@(posedge clk) disable iff (rst)
    $rose(framingFlag)
    |-> $past(frameEnd, 2))
    else $error("framing flag not two cycles after frame end");
endmodule

// *** dv/spi_host_model.sv ***
// Host serial model: frames of a chosen clock edge count
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic clk,
  output logic      sclkEdge,
  output logic      frameEnd
);
  initial begin
    sclkEdge = 1'b0;
    frameEnd = 1'b0;
  end
  // Bench repeats a frame or resets after a flag
  task automatic send(input int n);
    repeat (n) @(negedge clk) sclkEdge = 1'b1;
    @(negedge clk) sclkEdge = 1'b0;
    frameEnd = 1'b1;
    @(negedge clk) frameEnd = 1'b0;
  endtask
endmodule

// *** dv/tb_sticky_diag_error_flags.sv ***
// Self-checking bench for the sticky diagnostic flag register
`timescale 1ns/1ns
module tb_sticky_diag_error_flags;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclkEdge, frameEnd, overrun = 1'b0, flagsRead = 1'b0;
  logic        flashUpdateDone = 1'b0, flashUpdateOk = 1'b1;
  logic [15:0] readData, diagnosticErrorFlags;
  int          fail_count = 0;
  int          num_checks = 0;
  spi_host_model u_spi_host_model (.clk(clk), .sclkEdge(sclkEdge),
    .frameEnd(frameEnd));
  sticky_diag_error_flags u_sticky_diag_error_flags (.clk(clk), .rst(rst),
    .sclkEdge(sclkEdge), .frameEnd(frameEnd), .overrun(overrun),
    .flashUpdateDone(flashUpdateDone), .flashUpdateOk(flashUpdateOk),
    .flagsRead(flagsRead), .readData(readData),
    .diagnosticErrorFlags(diagnosticErrorFlags));
  initial forever #4 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd();
    @(negedge clk) flagsRead = 1'b1;
    @(negedge clk) flagsRead = 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk) overrun = 1'b1;
    @(negedge clk) overrun = 1'b0;
    check(diagnosticErrorFlags, 16'h0002);
    repeat (4) @(negedge clk);
    check(diagnosticErrorFlags, 16'h0002);
    rd();
    check(readData, 16'h0002);
    check(diagnosticErrorFlags, 16'h0000);
    // Error landing on the clearing read must survive it
    @(negedge clk) overrun = 1'b1;
    flagsRead = 1'b1;
    @(negedge clk) overrun = 1'b0;
    check(diagnosticErrorFlags, 16'h0002);
    // Back-to-back read picks up the surviving flag
    @(negedge clk) flagsRead = 1'b0;
    check(readData, 16'h0002);
    check(diagnosticErrorFlags, 16'h0000);
    flashUpdateDone = 1'b1;
    flashUpdateOk = 1'b0;
    repeat (2) @(negedge clk);
    rd();
    check(readData, 16'h0004);
    check(diagnosticErrorFlags, 16'h0004);
    flashUpdateDone = 1'b0;
    @(negedge clk) overrun = 1'b1;
    @(negedge clk) overrun = 1'b0;
    check(diagnosticErrorFlags, 16'h0006);
    // Host answers the overrun flag with a reset in mid-run
    rst = 1'b1;
    @(negedge clk) rst = 1'b0;
    check(diagnosticErrorFlags, 16'h0000);
    check(readData, 16'h0000);
    rd();
    rd();
    check(readData, 16'h0000);
    u_spi_host_model.send(15);
    repeat (2) @(negedge clk);
    check(diagnosticErrorFlags, 16'h0008);
    rd();
    check(readData, 16'h0008);
    // Host repeats the damaged transaction as a whole frame
    u_spi_host_model.send(16);
    repeat (2) @(negedge clk);
    check(diagnosticErrorFlags, 16'h0000);
    conclude();
  end
endmodule
